/* File: logic/tpr_pkg.sv */
// Shared constants for the tape position and sense responder
package tpr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_ERR = 8'h0c;
  localparam logic [7:0] OFF_INFO = 8'h10;
  localparam logic [7:0] OFF_DIAG = 8'h14;
  localparam logic [7:0] OFF_RESV = 8'h18;
  localparam logic [7:0] OFF_RSTAT = 8'h1c;
  // Command register fields
  localparam int CMD_INIT_LSB = 0;
  localparam int CMD_OP_LSB = 3;
  localparam int CMD_BT_BIT = 6;
  localparam int CMD_TP_BIT = 7;
  localparam int CMD_TPID_LSB = 8;
  localparam int CMD_LUN_BIT = 11;
  localparam int CMD_ALLOC_LSB = 12;
  // Error post register fields
  localparam int ERR_DEF_BIT = 3;
  localparam int ERR_KEY_LSB = 4;
  localparam int ERR_ASC_LSB = 8;
  localparam int ERR_ASCQ_LSB = 16;
  localparam int ERR_VALID_BIT = 24;
  localparam int ERR_FM_BIT = 25;
  localparam int ERR_EOM_BIT = 26;
  // Reservation register fields
  localparam int RESV_LUN_BIT = 3;
  localparam int RESV_TP_BIT = 4;
  localparam int RESV_TPID_LSB = 5;
  // Command selectors
  localparam logic [2:0] OP_POS = 3'h0;
  localparam logic [2:0] OP_DIAG = 3'h1;
  localparam logic [2:0] OP_REL = 3'h2;
  localparam logic [2:0] OP_SENSE = 3'h3;
  localparam logic [2:0] OP_WRITE = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  // Sense field values
  localparam logic [6:0] CODE_CUR = 7'h70;
  localparam logic [6:0] CODE_DEF = 7'h71;
  localparam logic [3:0] KEY_NONE = 4'h0;
  localparam logic [3:0] KEY_NOT_READY = 4'h2;
  localparam logic [3:0] KEY_MEDIUM = 4'h3;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_NOT_READY = 8'h04;
  localparam logic [7:0] ASCQ_EOP = 8'h02;
  localparam logic [7:0] ASCQ_BOP = 8'h04;
  localparam logic [7:0] ADD_LEN = 8'h0a;
  // Response lengths in bytes
  localparam logic [4:0] POS_LEN = 5'h14;
  localparam logic [4:0] SENSE_LEN = 5'h12;
  localparam logic [4:0] DIAG_LEN = 5'h02;
  localparam int RESP_BYTES = 20;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_DONE = 2'b11
  } tpr_state_e;
endpackage : tpr_pkg

/* File: logic/tpr_resp_mem.sv */
// Response byte memory with registered read data
`timescale 1ns/100ps
module tpr_resp_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_reg
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_reg <= mem[raddr];
  end
endmodule : tpr_resp_mem

/* File: logic/tpr_responder.sv */
// Target command responder: position, diagnostics, release and sense
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module tpr_responder #(
  parameter int NI = 8,
  parameter int MEM_DEPTH = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tape and buffer state
  input wire logic media_ready,
  input wire logic [31:0] logical_pos,
  input wire logic [31:0] physical_pos,
  input wire logic [23:0] buf_blocks,
  input wire logic [31:0] buf_bytes,
  input wire logic at_bop,
  input wire logic at_eop,
  input wire logic early_warning,
  input wire logic phys_eop,
  // Command completion
  output logic cmd_done,
  output logic check_condition
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int IW = $clog2(NI);
  localparam int VW = 8 * tpr_pkg::RESP_BYTES;

  tpr_pkg::tpr_state_e state_reg;
  logic [AW-1:0] fill_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [4:0] len_reg;
  logic [VW-1:0] resp_reg;
  logic [31:0] info_reg;
  logic [7:0] diag_mask_reg;
  logic diag_done_reg;
  logic [7:0] mem_rdata;
  logic [1:0] held;
  logic [2*IW-1:0] owner;

  // Per-initiator pending sense
  logic [NI-1:0] sp_pend;
  logic [NI-1:0] sp_def;
  logic [NI-1:0] sp_valid;
  logic [NI-1:0] sp_fm;
  logic [NI-1:0] sp_eom;
  logic [3:0] sp_key [NI];
  logic [7:0] sp_asc [NI];
  logic [7:0] sp_ascq [NI];
  logic [31:0] sp_info [NI];

  // Bus decode: one wait state on every access
  logic acc;
  logic wr_fire;
  logic mapped;
  logic start;
  logic pop;
  assign acc = psel && penable;
  assign wr_fire = acc && pready && pwrite;
  assign mapped = paddr[1:0] == 2'b00 && paddr <= tpr_pkg::OFF_RSTAT;
  assign start = wr_fire && paddr == tpr_pkg::OFF_CMD
    && state_reg != tpr_pkg::ST_FILL;
  assign pop = acc && pready && !pwrite && paddr == tpr_pkg::OFF_DATA
    && state_reg == tpr_pkg::ST_DONE && 5'(rd_ptr_reg) < len_reg;

  // Command fields
  logic [IW-1:0] c_init;
  logic [2:0] c_op;
  logic [7:0] c_alloc;
  assign c_init = pwdata[tpr_pkg::CMD_INIT_LSB +: IW];
  assign c_op = pwdata[tpr_pkg::CMD_OP_LSB +: 3];
  assign c_alloc = pwdata[tpr_pkg::CMD_ALLOC_LSB +: 8];

  // Sense error posting, from the command path or from software
  logic post_v;
  logic [IW-1:0] post_init;
  logic post_def;
  logic post_valid;
  logic post_fm;
  logic post_eom;
  logic [3:0] post_key;
  logic [7:0] post_asc;
  logic [7:0] post_ascq;
  logic [31:0] post_info;
  logic chk;

  always_comb begin
    post_v = 1'b0;
    post_init = c_init;
    post_def = 1'b0;
    post_valid = 1'b0;
    post_fm = 1'b0;
    post_eom = 1'b0;
    post_key = tpr_pkg::KEY_NONE;
    post_asc = tpr_pkg::ASC_NONE;
    post_ascq = 8'h00;
    post_info = 32'h0;
    chk = 1'b0;
    if (start) begin
      case (c_op)
        tpr_pkg::OP_POS: begin
          if (!media_ready) begin
            chk = 1'b1;
            post_key = tpr_pkg::KEY_NOT_READY;
            post_asc = tpr_pkg::ASC_NOT_READY;
          end
        end
        tpr_pkg::OP_WRITE: begin
          if (early_warning) begin
            chk = 1'b1;
            post_eom = 1'b1;
            post_ascq = tpr_pkg::ASCQ_EOP;
          end
        end
        tpr_pkg::OP_READ: begin
          if (phys_eop) begin
            chk = 1'b1;
            post_eom = 1'b1;
            post_key = tpr_pkg::KEY_MEDIUM;
            post_ascq = tpr_pkg::ASCQ_EOP;
          end
        end
        default: begin
          chk = 1'b0;
        end
      endcase
      post_v = chk;
    end else if (wr_fire && paddr == tpr_pkg::OFF_ERR) begin
      post_v = 1'b1;
      post_init = pwdata[IW-1:0];
      post_def = pwdata[tpr_pkg::ERR_DEF_BIT];
      post_key = pwdata[tpr_pkg::ERR_KEY_LSB +: 4];
      post_asc = pwdata[tpr_pkg::ERR_ASC_LSB +: 8];
      post_ascq = pwdata[tpr_pkg::ERR_ASCQ_LSB +: 8];
      post_valid = pwdata[tpr_pkg::ERR_VALID_BIT];
      post_fm = pwdata[tpr_pkg::ERR_FM_BIT];
      post_eom = pwdata[tpr_pkg::ERR_EOM_BIT];
      post_info = info_reg;
    end
  end

  // A post in the same edge as a discard wins, so no error is lost
  for (genvar i = 0; i < NI; i++) begin : g_sense
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sp_pend[i] <= 1'b0;
        sp_def[i] <= 1'b0;
        sp_valid[i] <= 1'b0;
        sp_fm[i] <= 1'b0;
        sp_eom[i] <= 1'b0;
        sp_key[i] <= 4'h0;
        sp_asc[i] <= 8'h00;
        sp_ascq[i] <= 8'h00;
        sp_info[i] <= 32'h0;
      end else if (post_v && post_init == IW'(i)) begin
        sp_pend[i] <= 1'b1;
        sp_def[i] <= post_def;
        sp_valid[i] <= post_valid;
        sp_fm[i] <= post_fm;
        sp_eom[i] <= post_eom;
        sp_key[i] <= post_key;
        sp_asc[i] <= post_asc;
        sp_ascq[i] <= post_ascq;
        sp_info[i] <= post_info;
      end else if (start && c_init == IW'(i)) begin
        sp_pend[i] <= 1'b0;
      end
    end
  end

  // Response images, big-endian byte order
  logic [31:0] last_loc;
  logic [VW-1:0] pos_vec;
  logic [143:0] sense_vec;
  logic [6:0] s_code;
  logic s_eom;
  logic [7:0] s_ascq;
  logic [7:0] s_alloc_len;

  // Buffer holding no whole block has nothing committed ahead of first
  assign last_loc = (buf_blocks == 24'h0) ? logical_pos
    : physical_pos;
  // Block-type flag is never looked at; unknown flag is constant zero
  assign pos_vec = {at_bop, at_eop, 6'h00, 8'h00, 16'h0000,
    logical_pos, last_loc, 8'h00,
    buf_blocks, buf_bytes};
  assign s_eom = at_bop || at_eop;
  assign s_ascq = at_eop ? tpr_pkg::ASCQ_EOP
    : at_bop ? tpr_pkg::ASCQ_BOP : 8'h00;
  assign s_code = sp_def[c_init] ? tpr_pkg::CODE_DEF
    : tpr_pkg::CODE_CUR;

  always_comb begin
    if (sp_pend[c_init]) begin
      sense_vec = {sp_valid[c_init], s_code, 8'h00,
        sp_fm[c_init], sp_eom[c_init] || s_eom, 2'b00, sp_key[c_init],
        sp_info[c_init], tpr_pkg::ADD_LEN, logical_pos,
        sp_asc[c_init], sp_ascq[c_init], 32'h0};
    end else begin
      // Logical position only, taken without touching the buffer
      sense_vec = {1'b0, tpr_pkg::CODE_CUR, 8'h00,
        1'b0, s_eom, 2'b00, tpr_pkg::KEY_NONE, 32'h0,
        tpr_pkg::ADD_LEN, logical_pos,
        tpr_pkg::ASC_NONE, s_ascq, 32'h0};
    end
  end

  assign s_alloc_len = (c_alloc < 8'(tpr_pkg::SENSE_LEN)) ? c_alloc
    : 8'(tpr_pkg::SENSE_LEN);

  // Command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tpr_pkg::ST_IDLE;
      fill_reg <= '0;
      len_reg <= 5'h00;
      resp_reg <= '0;
    end else if (start) begin
      fill_reg <= '0;
      state_reg <= tpr_pkg::ST_FILL;
      len_reg <= 5'h00;
      case (c_op)
        tpr_pkg::OP_POS: begin
          resp_reg <= pos_vec;
          len_reg <= media_ready ? tpr_pkg::POS_LEN : 5'h00;
        end
        tpr_pkg::OP_SENSE: begin
          resp_reg <= {sense_vec, 16'h0000};
          len_reg <= s_alloc_len[4:0];
        end
        tpr_pkg::OP_DIAG: begin
          resp_reg <= {diag_mask_reg, 7'h00, diag_done_reg,
            144'h0};
          if (diag_done_reg) begin
            len_reg <= (c_alloc < 8'(tpr_pkg::DIAG_LEN)) ? c_alloc[4:0]
              : tpr_pkg::DIAG_LEN;
          end
        end
        default: begin
          resp_reg <= '0;
        end
      endcase
    end else if (state_reg == tpr_pkg::ST_FILL) begin
      if (5'(fill_reg) + 5'h01 >= len_reg) begin
        state_reg <= tpr_pkg::ST_DONE;
      end
      fill_reg <= fill_reg + AW'(1);
    end
  end

  logic fill_we;
  logic [7:0] fill_byte;
  assign fill_we = state_reg == tpr_pkg::ST_FILL
    && 5'(fill_reg) < len_reg;
  assign fill_byte = resp_reg[8 * (tpr_pkg::RESP_BYTES - 1
    - int'(fill_reg)) +: 8];

  tpr_resp_mem #(
    .DW(8),
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .clk(pclk),
    .we(fill_we),
    .waddr(fill_reg),
    .wdata(fill_byte),
    .raddr(rd_ptr_reg),
    .rdata_reg(mem_rdata)
  );

  // Release and reservation holders
  logic rel_req;
  logic res_req;
  assign rel_req = start && c_op == tpr_pkg::OP_REL;
  assign res_req = wr_fire && paddr == tpr_pkg::OFF_RESV;

  tpr_resv_table #(
    .LUNS(2),
    .IW(IW)
  ) u_resv (
    .clk(pclk),
    .rst_n(presetn),
    .reserve_req(res_req),
    .release_req(rel_req),
    .req_init(res_req ? pwdata[IW-1:0] : c_init),
    .req_lun(res_req ? pwdata[tpr_pkg::RESV_LUN_BIT]
      : pwdata[tpr_pkg::CMD_LUN_BIT]),
    .req_tp(res_req ? pwdata[tpr_pkg::RESV_TP_BIT]
      : pwdata[tpr_pkg::CMD_TP_BIT]),
    .req_tp_id(res_req ? pwdata[tpr_pkg::RESV_TPID_LSB +: IW]
      : pwdata[tpr_pkg::CMD_TPID_LSB +: IW]),
    .held_reg(held),
    .owner_reg(owner)
  );

  // Read pointer into the reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg <= '0;
    end else if (start) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + AW'(1);
    end
  end

  // Software-written state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_reg <= 32'h0;
      diag_mask_reg <= 8'h00;
      diag_done_reg <= 1'b0;
    end else if (wr_fire && paddr == tpr_pkg::OFF_INFO) begin
      info_reg <= pwdata;
    end else if (wr_fire && paddr == tpr_pkg::OFF_DIAG) begin
      diag_mask_reg <= pwdata[7:0];
      diag_done_reg <= pwdata[8];
    end
  end

  // Completion outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_done <= 1'b0;
      check_condition <= 1'b0;
    end else begin
      cmd_done <= state_reg == tpr_pkg::ST_FILL
        && 5'(fill_reg) + 5'h01 >= len_reg;
      if (start) begin
        check_condition <= chk;
      end
    end
  end

  // APB answer; the wait state lets the memory read settle after a pop
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      tpr_pkg::OFF_STAT: rd_mux = {11'h0, 5'(rd_ptr_reg), 3'h0, len_reg,
        5'h00, state_reg == tpr_pkg::ST_DONE && 5'(rd_ptr_reg) < len_reg,
        check_condition, state_reg == tpr_pkg::ST_FILL};
      tpr_pkg::OFF_DATA: rd_mux = {24'h0, mem_rdata};
      tpr_pkg::OFF_INFO: rd_mux = info_reg;
      tpr_pkg::OFF_DIAG: rd_mux = {23'h0, diag_done_reg, diag_mask_reg};
      tpr_pkg::OFF_RSTAT: rd_mux = {16'h0, 8'(owner), 6'h00, held};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule : tpr_responder

/* File: logic/tpr_resv_table.sv */
// Per-unit reservation holders for drive and loader
`timescale 1ns/100ps
module tpr_resv_table #(
  parameter int LUNS = 2,
  parameter int IW = 3,
  parameter int LW = (LUNS > 1) ? $clog2(LUNS) : 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests
  input wire logic reserve_req,
  input wire logic release_req,
  input wire logic [IW-1:0] req_init,
  input wire logic [LW-1:0] req_lun,
  input wire logic req_tp,
  input wire logic [IW-1:0] req_tp_id,
  // State
  output logic [LUNS-1:0] held_reg,
  output logic [LUNS*IW-1:0] owner_reg
);
  logic [LUNS-1:0] tp_reg;
  logic [LUNS*IW-1:0] tp_id_reg;

  // Each unit is reserved whole; no per-element state exists
  for (genvar l = 0; l < LUNS; l++) begin : g_lun
    logic hit;
    logic own_match;
    assign hit = (req_lun == LW'(l));
    assign own_match = held_reg[l] && owner_reg[l*IW +: IW] == req_init
      && tp_reg[l] == req_tp
      && (!req_tp || tp_id_reg[l*IW +: IW] == req_tp_id);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        held_reg[l] <= 1'b0;
        owner_reg[l*IW +: IW] <= '0;
        tp_reg[l] <= 1'b0;
        tp_id_reg[l*IW +: IW] <= '0;
      end else if (reserve_req && hit && !held_reg[l]) begin
        held_reg[l] <= 1'b1;
        owner_reg[l*IW +: IW] <= req_init;
        tp_reg[l] <= req_tp;
        tp_id_reg[l*IW +: IW] <= req_tp_id;
      end else if (release_req && hit && own_match) begin
        // Other owners and unheld units are left alone, no error
        held_reg[l] <= 1'b0;
      end
    end
  end
endmodule : tpr_resv_table

/* File: tb/tpr_responder_props.sv */
// Port assertions for the tape position and sense responder
`timescale 1ns/100ps
module tpr_responder_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Tape state and status
  input wire logic media_ready,
  input wire logic early_warning,
  input wire logic phys_eop,
  input wire logic cmd_done,
  input wire logic check_condition
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cw;
  logic [2:0] op;
  assign cw = psel && penable && pready && pwrite &&
              paddr == tpr_pkg::OFF_CMD;
  assign op = pwdata[tpr_pkg::CMD_OP_LSB +: 3];
  chk_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // Misaligned words are outside the map as well
  chk_err_map: assert property (pready |->
    pslverr == (paddr > tpr_pkg::OFF_RSTAT || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address map");
  chk_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("cmd_done longer than one cycle");
  chk_pos_absent: assert property (
    cw && op == tpr_pkg::OP_POS && !media_ready
    |=> check_condition ##1 cmd_done)
    else $error("position without medium did not end in check");
  chk_pos_reply: assert property (
    cw && op == tpr_pkg::OP_POS && media_ready
    |=> !check_condition ##[19:21] cmd_done)
    else $error("position reply status or length wrong");
  chk_write_warn: assert property (
    cw && op == tpr_pkg::OP_WRITE && early_warning |=> check_condition)
    else $error("write past early warning not checked");
  chk_read_end: assert property (
    cw && op == tpr_pkg::OP_READ |=> check_condition == $past(phys_eop))
    else $error("read check does not follow physical end");
  chk_release_ok: assert property (
    cw && op == tpr_pkg::OP_REL |=> !check_condition)
    else $error("release ended in check");
endmodule : tpr_responder_props
bind tpr_responder tpr_responder_props u_tpr_responder_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .media_ready,
  .early_warning, .phys_eop, .cmd_done, .check_condition);

/* File: tb/tpr_responder_tb.sv */
// Self-checking bench for the tape position and sense responder
`timescale 1ns/100ps
module tpr_responder_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, cmd_done, check_condition, e;
  logic media_ready = 1'b1, at_bop = 1'b0, at_eop = 1'b0;
  logic early_warning = 1'b0, phys_eop = 1'b0;
  logic put_blk = 1'b0, put_fm = 1'b0, flush = 1'b0;
  logic [31:0] logical_pos, physical_pos, buf_bytes;
  logic [23:0] buf_blocks;
  logic [7:0] exp [0:19];
  int n_mismatch = 0, checked = 0;
  always #2 pclk = ~pclk;
  tpr_tape_model u_tpr_tape_model (.pclk, .presetn, .put_blk, .put_fm,
    .flush, .logical_pos, .physical_pos, .buf_blocks, .buf_bytes);
  tpr_responder u_tpr_responder (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .media_ready, .logical_pos,
    .physical_pos, .buf_blocks, .buf_bytes, .at_bop, .at_eop, .early_warning,
    .phys_eop, .cmd_done, .check_condition);
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task quit;
    n_mismatch++;
    give_verdict();
  endtask : quit
  task cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : cmp
  // Ends one idle edge later so psel is never set twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
      quit();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    cmp(q, want);
  endtask : rdc
  task cmd(input logic [2:0] ini, input logic [2:0] op, input logic [5:0] f,
           input logic [7:0] al);
    int i;
    apb(1'b1, tpr_pkg::OFF_CMD, {12'h000, al, f, op, ini});
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (cmd_done !== 1'b1 && i < 40);
    if (cmd_done !== 1'b1)
      quit();
  endtask : cmd
  // Reply length and check status, then every reply byte
  task reply(input logic [4:0] n, input logic chk);
    apb(1'b0, tpr_pkg::OFF_STAT, 32'h0);
    cmp({26'h0, q[12:8], q[1]}, {26'h0, n, chk});
    for (int k = 0; k < n; k++)
      rdc(tpr_pkg::OFF_DATA, {24'h0, exp[k]});
  endtask : reply
  task put32(input int k, input logic [31:0] v);
    exp[k] = v[31:24];
    exp[k+1] = v[23:16];
    exp[k+2] = v[15:8];
    exp[k+3] = v[7:0];
  endtask : put32
  task sense0(input logic [7:0] b2, input logic [7:0] b13);
    foreach (exp[k])
      exp[k] = 8'h00;
    exp[0] = 8'h70;
    exp[2] = b2;
    exp[7] = 8'h0a;
    put32(8, 32'h4);
    exp[13] = b13;
  endtask : sense0
  task hold(input logic [1:0] h);
    apb(1'b0, tpr_pkg::OFF_RSTAT, 32'h0);
    cmp({30'h0, q[1:0]}, {30'h0, h});
  endtask : hold
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(tpr_pkg::OFF_STAT, 32'h0);
    rdc(tpr_pkg::OFF_RSTAT, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, e}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    cmp({31'h0, e}, 32'h1);
    // Three blocks and a filemark left in the buffer
    put_blk <= 1'b1;
    repeat (3) @(posedge pclk);
    put_blk <= 1'b0;
    put_fm <= 1'b1;
    @(posedge pclk);
    put_fm <= 1'b0;
    @(posedge pclk);
    for (int bt = 0; bt < 2; bt++) begin
      foreach (exp[k])
        exp[k] = 8'h00;
      put32(4, 32'h4);
      put32(12, 32'h3);
      put32(16, 32'h600);
      cmd(3'h1, tpr_pkg::OP_POS, 6'(bt), 8'h00);
      reply(5'd20, 1'b0);
    end
    flush <= 1'b1;
    at_bop <= 1'b1;
    @(posedge pclk);
    flush <= 1'b0;
    @(posedge pclk);
    foreach (exp[k])
      exp[k] = 8'h00;
    exp[0] = 8'h80;
    put32(4, 32'h4);
    put32(8, 32'h4);
    cmd(3'h1, tpr_pkg::OP_POS, 6'h00, 8'h00);
    reply(5'd20, 1'b0);
    sense0(8'h40, 8'h04);
    cmd(3'h2, tpr_pkg::OP_SENSE, 6'h00, 8'd18);
    reply(5'd18, 1'b0);
    at_bop <= 1'b0;
    media_ready <= 1'b0;
    cmd(3'h1, tpr_pkg::OP_POS, 6'h00, 8'h00);
    reply(5'd0, 1'b1);
    media_ready <= 1'b1;
    sense0(8'h02, 8'h00);
    exp[12] = 8'h04;
    cmd(3'h1, tpr_pkg::OP_SENSE, 6'h00, 8'd18);
    reply(5'd18, 1'b0);
    sense0(8'h00, 8'h00);
    cmd(3'h1, tpr_pkg::OP_SENSE, 6'h00, 8'd8);
    reply(5'd8, 1'b0);
    apb(1'b1, tpr_pkg::OFF_INFO, 32'h01020304);
    apb(1'b1, tpr_pkg::OFF_ERR, 32'h0300113d);
    cmd(3'h6, tpr_pkg::OP_SENSE, 6'h00, 8'd8);
    reply(5'd8, 1'b0);
    sense0(8'h83, 8'h00);
    exp[0] = 8'hf1;
    put32(3, 32'h01020304);
    exp[7] = 8'h0a;
    exp[12] = 8'h11;
    cmd(3'h5, tpr_pkg::OP_SENSE, 6'h00, 8'd18);
    reply(5'd18, 1'b0);
    // Diagnostic reply is empty until the done bit is set, then both bytes
    cmd(3'h0, tpr_pkg::OP_DIAG, 6'h00, 8'd2);
    reply(5'd0, 1'b0);
    apb(1'b1, tpr_pkg::OFF_DIAG, 32'h15a);
    exp[0] = 8'h5a;
    exp[1] = 8'h01;
    cmd(3'h0, tpr_pkg::OP_DIAG, 6'h00, 8'd2);
    reply(5'd2, 1'b0);
    apb(1'b1, tpr_pkg::OFF_RESV, 32'h3);
    apb(1'b1, tpr_pkg::OFF_RESV, 32'hc);
    rdc(tpr_pkg::OFF_RSTAT, 32'h2303);
    cmd(3'h5, tpr_pkg::OP_REL, 6'h00, 8'h00);
    hold(2'b11);
    cmd(3'h3, tpr_pkg::OP_REL, 6'h20, 8'h00);
    hold(2'b11);
    cmd(3'h3, tpr_pkg::OP_REL, 6'h00, 8'h00);
    reply(5'd0, 1'b0);
    hold(2'b10);
    apb(1'b1, tpr_pkg::OFF_RESV, 32'hd2);
    cmd(3'h2, tpr_pkg::OP_REL, 6'h16, 8'h00);
    hold(2'b11);
    cmd(3'h2, tpr_pkg::OP_REL, 6'h1a, 8'h00);
    hold(2'b10);
    early_warning <= 1'b1;
    cmd(3'h1, tpr_pkg::OP_WRITE, 6'h00, 8'h00);
    reply(5'd0, 1'b1);
    sense0(8'h40, 8'h02);
    cmd(3'h1, tpr_pkg::OP_SENSE, 6'h00, 8'd18);
    reply(5'd18, 1'b0);
    cmd(3'h1, tpr_pkg::OP_READ, 6'h00, 8'h00);
    reply(5'd0, 1'b0);
    phys_eop <= 1'b1;
    cmd(3'h1, tpr_pkg::OP_READ, 6'h00, 8'h00);
    reply(5'd0, 1'b1);
    sense0(8'h43, 8'h02);
    cmd(3'h1, tpr_pkg::OP_SENSE, 6'h00, 8'd18);
    reply(5'd18, 1'b0);
    // Partition end: position flag and unsolicited sense qualifier
    at_eop <= 1'b1;
    sense0(8'h40, 8'h02);
    cmd(3'h4, tpr_pkg::OP_SENSE, 6'h00, 8'd40);
    reply(5'd18, 1'b0);
    foreach (exp[k])
      exp[k] = 8'h00;
    exp[0] = 8'h40;
    put32(4, 32'h4);
    put32(8, 32'h4);
    cmd(3'h4, tpr_pkg::OP_POS, 6'h00, 8'h00);
    reply(5'd20, 1'b0);
    give_verdict();
  end
endmodule : tpr_responder_tb

/* File: tb/tpr_tape_model.sv */
// Tape side model: position and buffer counts
`timescale 1ns/100ps
module tpr_tape_model #(
  parameter int BSZ = 512
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Recording events
  input wire logic put_blk,
  input wire logic put_fm,
  input wire logic flush,
  // Position and buffer state
  output logic [31:0] logical_pos,
  output logic [31:0] physical_pos,
  output logic [23:0] buf_blocks,
  output logic [31:0] buf_bytes
);
  // Objects not yet on tape; only an explicit flush commits them
  logic [31:0] pend_reg;
  assign physical_pos = logical_pos - pend_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      logical_pos <= 32'h0;
      pend_reg <= 32'h0;
      buf_blocks <= 24'h0;
      buf_bytes <= 32'h0;
    end else if (flush) begin
      pend_reg <= 32'h0;
      buf_blocks <= 24'h0;
      buf_bytes <= 32'h0;
    end else if (put_blk || put_fm) begin
      logical_pos <= logical_pos + 32'h1;
      pend_reg <= pend_reg + 32'h1;
      buf_blocks <= buf_blocks + {23'h0, put_blk};
      buf_bytes <= buf_bytes + (put_blk ? 32'(BSZ) : 32'h0);
    end
  end
endmodule : tpr_tape_model
